// ### logic/cc_pkg.sv
// Purpose: Shared constants and types for the CPU control and register bank block.
// Assumes: 16-bit data address space, 8-bit data bytes, one clock.
// Notes:   Status-word bit positions and the visible register addresses live here.
package cc_pkg;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam logic [15:0] SFR_LO    = 16'hff00;
    localparam logic [15:0] SFR_HI    = 16'hffff;
    localparam logic [15:0] GPR_LO    = 16'hfee0;
    localparam logic [15:0] GPR_HI    = 16'hfeff;
    localparam logic [15:0] RAM_LO    = 16'hfb00;
    localparam logic [15:0] RAM_HI    = 16'hfeff;
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] BRK_VEC   = 16'h003e;
    localparam logic [15:0] ADR_PC    = 16'hfff8;
    localparam logic [15:0] ADR_SP    = 16'hfffc;
    localparam logic [15:0] ADR_PSW   = 16'hfffe;
    localparam logic [7:0]  LCD_LAST  = 8'h03;

    // ------------------------------------------------------------------
    // Register bank geometry
    // ------------------------------------------------------------------
    localparam int unsigned GPR_N  = 32;
    localparam int unsigned GPR_IW = 5;

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    localparam logic [7:0]  PSW_RST = 8'h02;
    localparam int unsigned PSW_IE  = 7;
    localparam int unsigned PSW_Z   = 6;
    localparam int unsigned PSW_RB1 = 5;
    localparam int unsigned PSW_AC  = 4;
    localparam int unsigned PSW_RB0 = 3;
    localparam int unsigned PSW_ISP = 1;
    localparam int unsigned PSW_CY  = 0;
    localparam int unsigned STAT_ERR = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_VEC_LO   = 4'h0,
        ST_VEC_HI   = 4'h1,
        ST_VEC_END  = 4'h2,
        ST_RUN      = 4'h3,
        ST_PUSH_PSW = 4'h4,
        ST_PUSH_PCH = 4'h5,
        ST_PUSH_PCL = 4'h6,
        ST_POP_PCL  = 4'h7,
        ST_POP_PCH  = 4'h8,
        ST_POP_PSW  = 4'h9,
        ST_POP_END  = 4'ha
    } cc_state_e;

    typedef enum logic [2:0] {
        ALU_NONE = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_SUB  = 3'h2,
        ALU_ROL  = 3'h3,
        ALU_ROR  = 3'h4,
        ALU_CYLD = 3'h5,
        ALU_CYAN = 3'h6,
        ALU_CYOR = 3'h7
    } cc_alu_e;

endpackage

// ### logic/cc_gpr_bank.sv
// Purpose: Thirty-two byte general register array with byte and pair access.
// Assumes: Pair accesses use an even index; bit 0 of the index is ignored for them.
// Notes:   Port b wins over port a when both write the same byte in one cycle.
`timescale 1ns/1ps
`default_nettype none
module cc_gpr_bank
    import cc_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              a_we_i,
    input  wire logic              a_wide_i,
    input  wire logic [GPR_IW-1:0] a_idx_i,
    input  wire logic [15:0]       a_wdata_i,
    output logic      [15:0]       a_rdata_o,
    input  wire logic              b_we_i,
    input  wire logic              b_wide_i,
    input  wire logic [GPR_IW-1:0] b_idx_i,
    input  wire logic [15:0]       b_wdata_i,
    output logic      [15:0]       b_rdata_o
);

    // The banks carry no reset: their contents are undefined until written.
    logic [7:0] mem [GPR_N];

    for (genvar i = 0; i < GPR_N; i++) begin : g_ent
        localparam logic [GPR_IW-1:0] IDX = GPR_IW'(i);
        logic a_hit;
        logic b_hit;
        assign a_hit = a_we_i && (a_wide_i ? a_idx_i[GPR_IW-1:1] == IDX[GPR_IW-1:1]
                                           : a_idx_i == IDX);
        assign b_hit = b_we_i && (b_wide_i ? b_idx_i[GPR_IW-1:1] == IDX[GPR_IW-1:1]
                                           : b_idx_i == IDX);
        always_ff @(posedge ref_clk_i) begin
            if (b_hit) begin
                mem[i] <= (b_wide_i && IDX[0]) ? b_wdata_i[15:8] : b_wdata_i[7:0];
            end else if (a_hit) begin
                mem[i] <= (a_wide_i && IDX[0]) ? a_wdata_i[15:8] : a_wdata_i[7:0];
            end
        end
    end

    assign a_rdata_o = {mem[{a_idx_i[GPR_IW-1:1], 1'b1}], mem[{a_idx_i[GPR_IW-1:1], 1'b0}]};
    assign b_rdata_o = {mem[{b_idx_i[GPR_IW-1:1], 1'b1}], mem[{b_idx_i[GPR_IW-1:1], 1'b0}]};

endmodule
`default_nettype wire

// ### logic/cc_core_ctrl.sv
// Purpose: Instruction pointer, status word, stack pointer and register banks of the core.
// Assumes: The executor drives one command per cycle while busy_o is low.
// Notes:   Stack and vector memories answer a read in the cycle after the strobe.
//
// Operation
// RULE_01 - Addresses FF00H to FFFFH are decoded as the special register window.
// RULE_02 - Software never touches unassigned addresses inside that window.
// RULE_03 - Instruction pointer advances by the fetched instruction's byte length.
// RULE_04 - Branches load the pointer from immediate data or register contents.
// RULE_05 - Reset loads the pointer from vector bytes 0000H and 0001H.
// RULE_06 - Vector low byte comes from the even address, high byte from odd.
// RULE_07 - Status word is pushed on interrupt or push, restored by returns or pop.
// RULE_08 - Reset sets the status word to 02H.
// RULE_09 - Global enable clear refuses all maskable requests; else flags decide.
// RULE_10 - Enable flag cleared by disable or acknowledge, set by enable.
// RULE_11 - Zero flag is set for a zero result and cleared otherwise.
// RULE_12 - Two bank-select bits pick one of four banks, written by bank switch.
// RULE_13 - Half-carry flag marks carry out of or borrow into bit 3.
// RULE_14 - Low-priority requests are refused while the service-level flag is 0.
// RULE_15 - Carry holds add/sub overflow, rotate shift-out and the bit accumulator.
// RULE_16 - The stack pointer addresses only internal high-speed RAM.
// RULE_17 - Stack pointer decrements before each push and increments after each pop.
// RULE_18 - Software loads the stack pointer before using the stack.
// RULE_19 - General registers occupy FEE0H to FEFFH as four banks of eight bytes.
// RULE_20 - Registers work as single bytes or as four 16-bit pairs.
// RULE_21 - Display controller offsets 00H to 03H also hold special registers.
// RULE_22 - Special registers are accessed in their own units; pairs at even addresses.
// RULE_23 - Bank 0 sits at the top of the register area, bank 3 at the bottom.
// RULE_24 - Interrupt entry pushes status and return address; returns pop three bytes.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cc_core_ctrl
    import cc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_wide_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    output logic      [15:0] bus_rdata_o,
    output logic             sfr_hit_o,
    input  wire logic        lcd_acc_i,
    input  wire logic [7:0]  lcd_off_i,
    output logic             lcd_sfr_hit_o,
    input  wire logic        step_i,
    input  wire logic [2:0]  step_len_i,
    input  wire logic        branch_i,
    input  wire logic        branch_reg_i,
    input  wire logic [15:0] branch_target_i,
    input  wire logic        unmask_all_instr_i,
    input  wire logic        mask_all_instr_i,
    input  wire logic        bank_switch_instr_i,
    input  wire logic [1:0]  bank_num_i,
    input  wire logic        push_psw_i,
    input  wire logic        pop_psw_i,
    input  wire logic        irq_return_instr_i,
    input  wire logic        break_return_instr_i,
    input  wire logic        brk_i,
    input  wire cc_alu_e     alu_op_i,
    input  wire logic [7:0]  alu_a_i,
    input  wire logic [7:0]  alu_b_i,
    input  wire logic        alu_bit_i,
    output logic      [7:0]  alu_res_o,
    input  wire logic [2:0]  gpr_sel_i,
    input  wire logic        gpr_wide_i,
    input  wire logic        gpr_we_i,
    input  wire logic [15:0] gpr_wdata_i,
    output logic      [15:0] gpr_rdata_o,
    input  wire logic        irq_req_i,
    input  wire logic        irq_masked_i,
    input  wire logic        irq_low_prio_i,
    input  wire logic [15:0] irq_vector_i,
    output logic             irq_ack_o,
    output logic             stk_we_o,
    output logic             stk_re_o,
    output logic      [15:0] stk_addr_o,
    output logic      [7:0]  stk_wdata_o,
    input  wire logic [7:0]  stk_rdata_i,
    output logic             vec_re_o,
    output logic      [15:0] vec_addr_o,
    input  wire logic [7:0]  vec_rdata_i,
    output logic             busy_o,
    output logic      [15:0] instruction_pointer_o,
    output logic      [7:0]  status_word_o,
    output logic      [15:0] stack_pointer_o,
    output logic             stk_err_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        cc_state_e   st;
        logic [15:0] pc;
        logic [7:0]  status_word;
        logic [15:0] sp;
        logic        full;
        logic [15:0] vec;
        logic [7:0]  tmp;
        logic [7:0]  alu_res;
        logic        stk_err;
        logic [15:0] rdata;
    } cc_ctrl_s;

    localparam cc_ctrl_s RST_VAL = '{
        st: ST_VEC_LO, pc: '0, status_word: PSW_RST, sp: '0, full: 1'b0,
        vec: RESET_VEC, tmp: '0, alu_res: '0, stk_err: 1'b0, rdata: '0 };

    cc_ctrl_s r;
    cc_ctrl_s next_r;

    logic [15:0] bus_ea;
    logic        in_gpr;
    logic [15:0] bus_gpr_pair;
    logic [15:0] core_gpr_pair;
    logic [1:0]  bank;
    logic        accept;
    logic        push_ok;
    logic        pop_ok;
    logic [15:0] push_addr;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign bus_ea = bus_wide_i ? {bus_addr_i[15:1], 1'b0} : bus_addr_i; // [RULE_22]
    assign in_gpr = bus_ea >= GPR_LO && bus_ea <= GPR_HI;               // [RULE_19]
    assign sfr_hit_o = (bus_rd_i || bus_wr_i) && bus_addr_i >= SFR_LO
                       && bus_addr_i <= SFR_HI;                          // [RULE_01]
    assign lcd_sfr_hit_o = lcd_acc_i && lcd_off_i <= LCD_LAST;         // [RULE_21]
    assign bank = {r.status_word[PSW_RB1], r.status_word[PSW_RB0]};
    assign push_addr = r.sp - 16'h0001;
    assign push_ok = push_addr >= RAM_LO && push_addr <= RAM_HI;        // [RULE_16]
    assign pop_ok = r.sp >= RAM_LO && r.sp <= RAM_HI;                   // [RULE_16]

    assign accept = r.st == ST_RUN && irq_req_i && r.status_word[PSW_IE] && !irq_masked_i
                    && (r.status_word[PSW_ISP] || !irq_low_prio_i);             // [RULE_09] [RULE_14]
    assign irq_ack_o = accept;
    assign busy_o = r.st != ST_RUN;

    // ------------------------------------------------------------------
    // Register banks
    // ------------------------------------------------------------------
    // Bank n lives at FEF8H - 8n, so the physical index is the inverted bank
    // number followed by the register number.
    cc_gpr_bank u_bank (
        .ref_clk_i (ref_clk_i),
        .a_we_i    (bus_wr_i && in_gpr),
        .a_wide_i  (bus_wide_i),
        .a_idx_i   (bus_ea[GPR_IW-1:0]),
        .a_wdata_i (bus_wdata_i),
        .a_rdata_o (bus_gpr_pair),
        .b_we_i    (gpr_we_i && r.st == ST_RUN),
        .b_wide_i  (gpr_wide_i),
        .b_idx_i   ({~bank, gpr_sel_i}),                                // [RULE_12] [RULE_23]
        .b_wdata_i (gpr_wdata_i),
        .b_rdata_o (core_gpr_pair)
    );

    // Pair read always; the executor picks the byte for 8-bit use.
    assign gpr_rdata_o = core_gpr_pair;                                 // [RULE_20]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] pair;
        logic [15:0] wv;
        logic [8:0]  sum;
        logic        err_set;
        pair = '0;
        wv = '0;
        sum = '0;
        err_set = 1'b0;
        next_r = r;
        stk_we_o = 1'b0;
        stk_re_o = 1'b0;
        stk_addr_o = r.sp;
        stk_wdata_o = r.status_word;
        vec_re_o = 1'b0;
        vec_addr_o = r.vec;

        // Bus read: the answer stands for exactly one cycle.
        if (in_gpr) begin
            pair = bus_gpr_pair;                                        // [RULE_19] [RULE_20]
        end else if ({bus_ea[15:1], 1'b0} == ADR_PC) begin
            pair = r.pc;
        end else if ({bus_ea[15:1], 1'b0} == ADR_SP) begin
            pair = r.sp;
        end else if ({bus_ea[15:1], 1'b0} == ADR_PSW) begin
            pair = {7'h00, r.stk_err, r.status_word};
        end
        // Unassigned window addresses read as zero and ignore writes.  [RULE_02]
        next_r.rdata = '0;
        if (bus_rd_i) begin
            next_r.rdata = bus_wide_i ? pair
                         : {8'h00, bus_ea[0] ? pair[15:8] : pair[7:0]};
        end

        // Bus write; the sequencer below overrides it in the same cycle.
        if (bus_wr_i) begin
            wv = bus_wide_i ? bus_wdata_i
               : bus_ea[0] ? {bus_wdata_i[7:0], pair[7:0]} : {pair[15:8], bus_wdata_i[7:0]};
            if ({bus_ea[15:1], 1'b0} == ADR_PC) begin
                next_r.pc = wv;
            end else if ({bus_ea[15:1], 1'b0} == ADR_SP) begin
                next_r.sp = wv;                                         // [RULE_18]
            end else if ({bus_ea[15:1], 1'b0} == ADR_PSW) begin
                next_r.status_word = wv[7:0];
                next_r.stk_err = r.stk_err && !(wv[STAT_ERR] && (bus_ea[0] || bus_wide_i));
            end
        end

        unique case (r.st)
            ST_VEC_LO: begin
                vec_re_o = 1'b1;
                next_r.st = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                next_r.tmp = vec_rdata_i;                               // [RULE_06]
                vec_re_o = 1'b1;
                vec_addr_o = r.vec + 16'h0001;
                next_r.st = ST_VEC_END;
            end
            ST_VEC_END: begin
                next_r.pc = {vec_rdata_i, r.tmp};                       // [RULE_05] [RULE_06]
                next_r.st = ST_RUN;
            end
            ST_RUN: begin
                next_r.tmp = r.status_word;
                if (accept || brk_i) begin
                    next_r.vec = accept ? irq_vector_i : BRK_VEC;
                    next_r.full = 1'b1;
                    next_r.st = ST_PUSH_PSW;                            // [RULE_24]
                    next_r.status_word[PSW_IE] = next_r.status_word[PSW_IE] && !accept; // [RULE_10]
                end else if (irq_return_instr_i || break_return_instr_i) begin
                    next_r.full = 1'b1;
                    next_r.st = ST_POP_PCL;                             // [RULE_24]
                end else if (push_psw_i) begin
                    next_r.full = 1'b0;
                    next_r.st = ST_PUSH_PSW;                            // [RULE_07]
                end else if (pop_psw_i) begin
                    next_r.full = 1'b0;
                    next_r.st = ST_POP_PSW;                             // [RULE_07]
                end else begin
                    if (branch_i) begin
                        next_r.pc = branch_reg_i ? core_gpr_pair : branch_target_i; // [RULE_04]
                    end else if (step_i) begin
                        next_r.pc = r.pc + {13'h0000, step_len_i};      // [RULE_03]
                    end
                    if (unmask_all_instr_i) begin
                        next_r.status_word[PSW_IE] = 1'b1;                      // [RULE_10]
                    end else if (mask_all_instr_i) begin
                        next_r.status_word[PSW_IE] = 1'b0;                      // [RULE_10]
                    end
                    if (bank_switch_instr_i) begin
                        next_r.status_word[PSW_RB1] = bank_num_i[1];            // [RULE_12]
                        next_r.status_word[PSW_RB0] = bank_num_i[0];
                    end
                    unique case (alu_op_i)
                        ALU_ADD: begin
                            sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
                            next_r.alu_res = sum[7:0];
                            next_r.status_word[PSW_CY] = sum[8];                // [RULE_15]
                            next_r.status_word[PSW_AC] = ({1'b0, alu_a_i[3:0]}
                                + {1'b0, alu_b_i[3:0]}) > 5'h0f;        // [RULE_13]
                            next_r.status_word[PSW_Z] = sum[7:0] == 8'h00;      // [RULE_11]
                        end
                        ALU_SUB: begin
                            sum = {1'b0, alu_a_i} - {1'b0, alu_b_i};
                            next_r.alu_res = sum[7:0];
                            next_r.status_word[PSW_CY] = alu_a_i < alu_b_i;     // [RULE_15]
                            next_r.status_word[PSW_AC] = alu_a_i[3:0] < alu_b_i[3:0]; // [RULE_13]
                            next_r.status_word[PSW_Z] = sum[7:0] == 8'h00;      // [RULE_11]
                        end
                        ALU_ROL: begin
                            next_r.alu_res = {alu_a_i[6:0], alu_a_i[7]};
                            next_r.status_word[PSW_CY] = alu_a_i[7];            // [RULE_15]
                        end
                        ALU_ROR: begin
                            next_r.alu_res = {alu_a_i[0], alu_a_i[7:1]};
                            next_r.status_word[PSW_CY] = alu_a_i[0];            // [RULE_15]
                        end
                        ALU_CYLD: next_r.status_word[PSW_CY] = alu_bit_i;       // [RULE_15]
                        ALU_CYAN: next_r.status_word[PSW_CY] = r.status_word[PSW_CY] & alu_bit_i;
                        ALU_CYOR: next_r.status_word[PSW_CY] = r.status_word[PSW_CY] | alu_bit_i;
                        ALU_NONE: next_r.alu_res = r.alu_res;
                    endcase
                end
            end
            ST_PUSH_PSW, ST_PUSH_PCH, ST_PUSH_PCL: begin
                // Decrement first, then write at the new address.
                stk_addr_o = push_addr;                                 // [RULE_17]
                stk_we_o = push_ok;                                     // [RULE_16]
                err_set = !push_ok;
                next_r.sp = push_addr;
                if (r.st == ST_PUSH_PSW) begin
                    stk_wdata_o = r.tmp;                                // [RULE_07]
                    next_r.st = r.full ? ST_PUSH_PCH : ST_RUN;
                end else if (r.st == ST_PUSH_PCH) begin
                    stk_wdata_o = r.pc[15:8];                           // [RULE_24]
                    next_r.st = ST_PUSH_PCL;
                end else begin
                    stk_wdata_o = r.pc[7:0];
                    next_r.st = ST_VEC_LO;
                end
            end
            ST_POP_PCL, ST_POP_PCH, ST_POP_PSW: begin
                // Read at the current address, then increment.
                stk_re_o = pop_ok;                                      // [RULE_16]
                err_set = !pop_ok;
                next_r.sp = r.sp + 16'h0001;                            // [RULE_17]
                if (r.st == ST_POP_PCL) begin
                    next_r.st = ST_POP_PCH;
                end else if (r.st == ST_POP_PCH) begin
                    next_r.tmp = stk_rdata_i;
                    next_r.st = ST_POP_PSW;
                end else begin
                    if (r.full) begin
                        next_r.pc = {stk_rdata_i, r.tmp};               // [RULE_24]
                    end
                    next_r.st = ST_POP_END;
                end
            end
            ST_POP_END: begin
                next_r.status_word = stk_rdata_i;                               // [RULE_07]
                next_r.st = ST_RUN;
            end
            default: next_r.st = ST_RUN;
        endcase

        // A stack fault in the same cycle as a software clear still lands.
        if (err_set) begin
            next_r.stk_err = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= RST_VAL;                                               // [RULE_05] [RULE_08]
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata_o = r.rdata;
    assign alu_res_o = r.alu_res;
    assign instruction_pointer_o = r.pc;
    assign status_word_o = r.status_word;
    assign stack_pointer_o = r.sp;
    assign stk_err_o = r.stk_err;

endmodule
`default_nettype wire

// ### sim/cc_core_ctrl_asserts.sv
// Purpose: Port-level checks of the core control block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module cc_core_ctrl_asserts
    import cc_pkg::*;
(
    input wire logic        ref_clk_i, rst_n_i, bus_wr_i, bus_rd_i, sfr_hit_o, lcd_acc_i,
    input wire logic        lcd_sfr_hit_o, step_i, branch_i, branch_reg_i, brk_i, push_psw_i,
    input wire logic        pop_psw_i, irq_return_instr_i, break_return_instr_i, irq_ack_o,
    input wire logic        stk_we_o, stk_re_o, busy_o,
    input wire logic [15:0] bus_addr_i, branch_target_i, stk_addr_o, instruction_pointer_o,
    input wire logic [15:0] stack_pointer_o,
    input wire logic [7:0]  lcd_off_i, status_word_o,
    input wire logic [2:0]  step_len_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Quiet cycles only: no sequence overrides the pointer update.
    wire logic plain = !busy_o && !irq_ack_o && !brk_i && !push_psw_i && !pop_psw_i
        && !irq_return_instr_i && !break_return_instr_i && !bus_wr_i;
    chk_sfr_window: assert property (
        sfr_hit_o == ((bus_rd_i || bus_wr_i) && bus_addr_i >= SFR_LO)) else $error("window");
    chk_lcd_window: assert property (
        lcd_sfr_hit_o == (lcd_acc_i && lcd_off_i <= 8'h03)) else $error("display window");
    chk_ip_step: assert property (plain && step_i && !branch_i |=>
        instruction_pointer_o == $past(instruction_pointer_o) + $past(step_len_i))
        else $error("step");
    chk_ip_branch: assert property (plain && branch_i && !branch_reg_i |=>
        instruction_pointer_o == $past(branch_target_i)) else $error("branch");
    chk_ie_refuse: assert property (
        !status_word_o[PSW_IE] |-> !irq_ack_o) else $error("ack while disabled");
    chk_ack_clears: assert property (
        irq_ack_o |=> !status_word_o[PSW_IE]) else $error("enable kept");
    chk_push_dec: assert property (
        stk_we_o |=> stack_pointer_o == $past(stk_addr_o)) else $error("push pointer");
    chk_pop_inc: assert property (
        stk_re_o |=> stack_pointer_o == $past(stk_addr_o) + 16'h1) else $error("pop pointer");
endmodule
bind cc_core_ctrl cc_core_ctrl_asserts chk (.*);
`default_nettype wire

// ### sim/cc_core_ctrl_test.sv
// Purpose: Directed bench for the core control block.
// Assumes: Memories modelled inline; every vector pair reads 1234h.
// Notes:   Ends through report_and_stop.
`timescale 1ns/1ps
`default_nettype none
module cc_core_ctrl_test import cc_pkg::*;;
    logic ref_clk_i = '0, rst_n_i = '0, bus_wide_i = '0, bus_wr_i = '0, bus_rd_i = '0;
    logic lcd_acc_i = '0, step_i = '0, branch_i = '0, branch_reg_i = '0, brk_i = '0;
    logic unmask_all_instr_i = '0, mask_all_instr_i = '0, bank_switch_instr_i = '0;
    logic push_psw_i = '0, pop_psw_i = '0, irq_return_instr_i = '0, break_return_instr_i = '0;
    logic alu_bit_i = '0, gpr_wide_i = '0, gpr_we_i = '0, irq_req_i = '0, irq_masked_i = '0;
    logic irq_low_prio_i = '0, sfr_hit_o, lcd_sfr_hit_o, irq_ack_o, stk_we_o, stk_re_o;
    logic vec_re_o, busy_o, stk_err_o;
    logic [1:0] bank_num_i = '0;
    logic [2:0] step_len_i = '0, gpr_sel_i = '0;
    logic [7:0] lcd_off_i = '0, alu_a_i = '0, alu_b_i = '0, alu_res_o, stk_wdata_o;
    logic [7:0] stk_rdata_i = '0, vec_rdata_i = '0, status_word_o, mem [256];
    logic [15:0] bus_addr_i = '0, bus_wdata_i = '0, branch_target_i = '0, gpr_wdata_i = '0;
    logic [15:0] irq_vector_i = 16'h0006, bus_rdata_o, gpr_rdata_o, stk_addr_o, vec_addr_o;
    logic [15:0] instruction_pointer_o, stack_pointer_o;
    cc_alu_e alu_op_i = ALU_NONE;
    int fail_count, n_compared;
    cc_core_ctrl dut (.*);
    initial forever #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (stk_we_o) mem[stk_addr_o[7:0]] <= stk_wdata_o;
        stk_rdata_i <= mem[stk_addr_o[7:0]];
        vec_rdata_i <= vec_addr_o[0] ? 8'h12 : 8'h34;
    end
    task chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task report_and_stop;
        $display("compared %0d, wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Waits out a sequence; a hang counts as a mismatch.
    task idle;
        for (int i = 0; i < 30 && busy_o !== 1'b0; i++) @(posedge ref_clk_i) #1;
        if (busy_o !== 1'b0) begin
            fail_count++;
            report_and_stop;
        end
    endtask
    task wr(input logic [15:0] a, d, input logic w);
        @(posedge ref_clk_i) {bus_addr_i, bus_wdata_i, bus_wide_i, bus_wr_i} <= {a, d, w, 1'b1};
        @(posedge ref_clk_i) bus_wr_i <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic w, input logic [15:0] exp);
        @(posedge ref_clk_i) {bus_addr_i, bus_wide_i, bus_rd_i} <= {a, w, 1'b1};
        @(posedge ref_clk_i) bus_rd_i <= 1'b0;
        #1 chk(bus_rdata_o, exp);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1 idle;
        chk(instruction_pointer_o, 16'h1234);
        rd(ADR_PSW, 1'b0, 16'h0002);
        wr(ADR_SP, 16'hfe20, 1'b1);
        wr(16'hfef8, 16'hbeef, 1'b1);
        rd(16'hfef9, 1'b0, 16'h00be);
        chk(gpr_rdata_o, 16'hbeef);
        rd(ADR_SP, 1'b1, 16'hfe20);
        @(posedge ref_clk_i) {bank_switch_instr_i, bank_num_i, lcd_acc_i} <= 4'b1111;
        @(posedge ref_clk_i) {bank_switch_instr_i, gpr_we_i, gpr_wide_i} <= 3'b011;
        gpr_wdata_i <= 16'h1357;
        @(posedge ref_clk_i) {gpr_we_i, step_i, step_len_i} <= 5'b01011;
        @(posedge ref_clk_i) {step_i, branch_i, branch_target_i} <= {2'b01, 16'h4000};
        #1 chk(instruction_pointer_o, 16'h1237);
        @(posedge ref_clk_i) branch_reg_i <= 1'b1;
        #1 chk(instruction_pointer_o, 16'h4000);
        @(posedge ref_clk_i) {branch_i, unmask_all_instr_i} <= 2'b01;
        #1 chk(instruction_pointer_o, 16'h1357);
        @(posedge ref_clk_i) {unmask_all_instr_i, irq_req_i} <= 2'b01;
        @(posedge ref_clk_i) irq_req_i <= 1'b0;
        #1 idle;
        chk({stack_pointer_o, mem[8'h1f], status_word_o}, 32'hfe1daa2a);
        @(posedge ref_clk_i) break_return_instr_i <= 1'b1;
        @(posedge ref_clk_i) break_return_instr_i <= 1'b0;
        #1 idle;
        chk({instruction_pointer_o, status_word_o}, 24'h1357aa);
        @(posedge ref_clk_i) {mask_all_instr_i, push_psw_i} <= 2'b10;
        @(posedge ref_clk_i) {mask_all_instr_i, irq_req_i, push_psw_i} <= 3'b011;
        @(posedge ref_clk_i) {irq_req_i, push_psw_i} <= 2'b00;
        #1 idle;
        chk({stack_pointer_o, mem[8'h1f]}, 24'hfe1f2a);
        @(posedge ref_clk_i) pop_psw_i <= 1'b1;
        @(posedge ref_clk_i) pop_psw_i <= 1'b0;
        #1 idle;
        chk({stk_err_o, stack_pointer_o}, 17'h0fe20);
        @(posedge ref_clk_i) {alu_a_i, alu_b_i} <= 16'h0f01;
        alu_op_i <= ALU_ADD;
        @(posedge ref_clk_i) {alu_a_i, alu_b_i} <= 16'hff01;
        #1 chk({alu_res_o, status_word_o[PSW_AC], status_word_o[PSW_Z]}, 10'h042);
        @(posedge ref_clk_i) alu_op_i <= ALU_NONE;
        #1 chk({alu_res_o, status_word_o[PSW_Z], status_word_o[PSW_CY]}, 10'h003);
        report_and_stop;
    end
endmodule
`default_nettype wire
